// >>> rtl/b4sram_top.sv
// device side of the burst-of-four split-port sram pin interface
// Operation
// - write lane only when write started, enable low
// - enables 0..3 govern nine-bit lanes upward, x8 uses 0..1 on nibbles
// - enables sampled on all four write edges
// - first word on c_n rise, second c
// - both output clocks high: use k edges
// - write data captured on k and k_n
// - narrow widths use low data bits only
// - dll disable low bypasses the dll
// - read address and control only on k rise
// - read select starts read, next ignored
// - write select starts a write burst
// - read addr at k, write at k_n
// - every burst moves four words
// - address ignored when no port selected
// - echo clocks aligned, run continuously
// - read data changes only for reads
// - internal offsets step 0,1,2,3 then stop
// - request on consecutive k rise rejected
// - read and write sequencers run independently
`timescale 1ns/1ps
module b4sram_top (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RESET_N,
  input  wire logic                          I_LINK_CLK,
  input  wire logic                          I_K_PHASE,
  input  wire logic                          I_READ_SELECT_N,
  input  wire logic                          I_WRITE_SELECT_N,
  input  wire logic [b4sram_pkg::ADDR_W-1:0] I_SHARED_ADDRESS_BUS,
  input  wire logic [b4sram_pkg::WORD_W-1:0] I_D,
  input  wire logic [b4sram_pkg::LANES-1:0]  I_BYTE_LANE_WRITE_ENABLE_N,
  input  wire logic                          I_OUT_CLK,
  input  wire logic                          I_OUT_CLK_N,
  input  wire logic                          I_DLL_DISABLE_N,
  input  wire logic [1:0]                    I_WIDTH_SEL,
  output logic      [b4sram_pkg::WORD_W-1:0] O_Q,
  output logic                               O_Q_OE,
  output logic                               O_ECHO_CLOCK,
  output logic                               O_ECHO_CLOCK_COMPLEMENT,
  output logic                               O_DLL_BYPASS,
  output logic                               O_DLL_READY
);

  b4sram_pkg::b4sram_link_type  st_reg;
  b4sram_pkg::b4sram_link_type  st_next;
  b4sram_pkg::b4sram_sys_type   sys_reg;
  b4sram_pkg::b4sram_sys_type   sys_next;
  b4sram_pkg::b4sram_cmd_type   cmd;
  b4sram_pkg::b4sram_memwr_type mem_wr;
  logic [1:0]                   lrst_sync_reg;
  logic                         link_rst_n;
  logic [b4sram_pkg::WORD_W-1:0] mem_rd_data;
  logic [b4sram_pkg::WORD_W-1:0] width_mask;
  logic                         rd_acc;
  logic                         wr_acc;
  logic                         kmode;
  logic                         c_rise;
  logic                         cn_rise;
  logic                         ref_ok;
  logic                         ref_any;
  logic                         load;
  logic                         is_x8;
  logic                         is_x18;

  // lane mask from enables and width strap
  function automatic logic [b4sram_pkg::WORD_W-1:0] lane_mask(
    input logic [b4sram_pkg::LANES-1:0] be_n,
    input logic                         x8,
    input logic                         x18
  );
    logic [b4sram_pkg::WORD_W-1:0] m;
    m = '0;
    if (x8) begin
      m[b4sram_pkg::NIBBLE_W-1:0]                    = {b4sram_pkg::NIBBLE_W{!be_n[0]}};
      m[b4sram_pkg::X8_W-1:b4sram_pkg::NIBBLE_W]     = {b4sram_pkg::NIBBLE_W{!be_n[1]}};
    end else begin
      for (int i = 0; i < b4sram_pkg::LANES; i++) begin
        m[i*b4sram_pkg::LANE_W +: b4sram_pkg::LANE_W] = {b4sram_pkg::LANE_W{!be_n[i]}};
      end
      if (x18) begin
        m[b4sram_pkg::WORD_W-1:b4sram_pkg::X18_W] = '0;
      end
    end
    return m;
  endfunction

  // link reset: async assert, release synchronised to the link clock
  always_ff @(posedge I_LINK_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      lrst_sync_reg <= 2'h0;
    end else begin
      lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
    end
  end
  assign link_rst_n = lrst_sync_reg[1];

  assign cmd.kphase = I_K_PHASE;
  assign cmd.rd_n   = I_READ_SELECT_N;
  assign cmd.wr_n   = I_WRITE_SELECT_N;
  assign cmd.addr   = I_SHARED_ADDRESS_BUS;
  assign cmd.data   = I_D;
  assign cmd.be_n   = I_BYTE_LANE_WRITE_ENABLE_N;
  assign cmd.c      = I_OUT_CLK;
  assign cmd.c_n    = I_OUT_CLK_N;

  assign is_x8      = (st_reg.wsel_s2 == b4sram_pkg::WSEL_X8);
  assign is_x18     = (st_reg.wsel_s2 == b4sram_pkg::WSEL_X18);
  assign width_mask = is_x8  ? 36'h0_0000_00FF :
                      is_x18 ? 36'h0_0003_FFFF : 36'hF_FFFF_FFFF;

  // commands only on true k rise, never twice on consecutive k rises
  assign rd_acc = cmd.kphase && !cmd.rd_n && st_reg.rdy_s2 && !st_reg.rd_acc_prev;
  assign wr_acc = cmd.kphase && !cmd.wr_n && st_reg.rdy_s2 && !st_reg.wr_acc_prev;

  // both output clocks seen high twice: relies on them staying static
  assign kmode   = cmd.c && cmd.c_n && st_reg.c_prev && st_reg.cn_prev;
  assign c_rise  = cmd.c && !st_reg.c_prev;
  assign cn_rise = cmd.c_n && !st_reg.cn_prev;
  // even words on the complement edge, odd words on the true edge
  assign ref_ok  = kmode ? (st_reg.out_ptr[0] == cmd.kphase)
                         : (st_reg.out_ptr[0] ? c_rise : cn_rise);
  assign ref_any = kmode || c_rise || cn_rise;
  assign load    = ref_ok && (st_reg.pending != 3'h0);

  // write beats land on consecutive k and k_n edges after the address edge
  assign mem_wr.we   = st_reg.wr_active;
  assign mem_wr.addr = {st_reg.wr_addr, st_reg.wr_beat};
  assign mem_wr.data = cmd.data;
  assign mem_wr.mask = st_reg.wr_active ? lane_mask(cmd.be_n, is_x8, is_x18) : '0;

  b4sram_mem u_mem (
    .i_clk     (I_LINK_CLK),
    .i_rst_n   (link_rst_n),
    .i_wr      (mem_wr),
    .i_rd_en   (st_reg.rd_active),
    .i_rd_addr ({st_reg.rd_addr, st_reg.rd_beat}),
    .o_rd_data (mem_rd_data)
  );

  always_comb begin
    st_next = st_reg;
    st_next.wsel_s1 = I_WIDTH_SEL;
    st_next.wsel_s2 = st_reg.wsel_s1;
    st_next.rdy_s1  = sys_reg.ready;
    st_next.rdy_s2  = st_reg.rdy_s1;
    st_next.c_prev  = cmd.c;
    st_next.cn_prev = cmd.c_n;
    if (cmd.kphase) begin
      st_next.rd_acc_prev = rd_acc;
      st_next.wr_acc_prev = wr_acc;
    end
    // read sequencer: address held only when a read is taken
    if (rd_acc) begin
      st_next.rd_addr   = cmd.addr;
      st_next.rd_active = 1'b1;
      st_next.rd_beat   = 2'h0;
    end else if (st_reg.rd_active) begin
      st_next.rd_beat = st_reg.rd_beat + 2'h1;
      if (st_reg.rd_beat == b4sram_pkg::BEAT_LAST) begin
        st_next.rd_active = 1'b0;
      end
    end
    // fetched words park in a four-slot ring until their output edge
    st_next.fill_pend = st_reg.rd_active;
    if (st_reg.fill_pend) begin
      st_next.rd_buf[st_reg.fill_ptr] = mem_rd_data;
      st_next.fill_ptr = st_reg.fill_ptr + 2'h1;
    end
    st_next.pending = st_reg.pending + {2'h0, st_reg.fill_pend} - {2'h0, load};
    if (load) begin
      st_next.q       = st_reg.rd_buf[st_reg.out_ptr] & width_mask;
      st_next.q_oe    = 1'b1;
      st_next.out_ptr = st_reg.out_ptr + 2'h1;
    end else if (ref_any) begin
      st_next.q_oe = 1'b0;
    end
    // write sequencer runs alongside the read one
    if (wr_acc) begin
      st_next.wr_addr_pend = 1'b1;
    end
    if (st_reg.wr_addr_pend) begin
      st_next.wr_addr      = cmd.addr;
      st_next.wr_addr_pend = wr_acc;
      st_next.wr_active    = 1'b1;
      st_next.wr_beat      = 2'h0;
    end else if (st_reg.wr_active) begin
      st_next.wr_beat = st_reg.wr_beat + 2'h1;
      if (st_reg.wr_beat == b4sram_pkg::BEAT_LAST) begin
        st_next.wr_active = 1'b0;
      end
    end
    // echo follows the edge that times the data, every link edge
    st_next.echo = kmode ? cmd.kphase : cmd.c;
  end

  always_ff @(posedge I_LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_reg <= b4sram_pkg::LINK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // dll model on the core clock; bypass needs no lock wait
  always_comb begin
    sys_next = sys_reg;
    sys_next.dll_s1 = I_DLL_DISABLE_N;
    sys_next.dll_s2 = sys_reg.dll_s1;
    if (!sys_reg.dll_s2) begin
      sys_next.bypass   = 1'b1;
      sys_next.ready    = 1'b1;
      sys_next.lock_cnt = 8'h00;
    end else begin
      sys_next.bypass = 1'b0;
      if (sys_reg.lock_cnt != b4sram_pkg::DLL_LOCK_COUNT) begin
        sys_next.lock_cnt = sys_reg.lock_cnt + 8'h01;
        sys_next.ready    = 1'b0;
      end else begin
        sys_next.ready = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sys_reg <= b4sram_pkg::SYS_RESET;
    end else begin
      sys_reg <= sys_next;
    end
  end

  assign O_Q                     = st_reg.q;
  assign O_Q_OE                  = st_reg.q_oe;
  assign O_ECHO_CLOCK            = st_reg.echo;
  assign O_ECHO_CLOCK_COMPLEMENT = !st_reg.echo;
  assign O_DLL_BYPASS            = sys_reg.bypass;
  assign O_DLL_READY             = sys_reg.ready;

  chk_lane_gate: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (mem_wr.mask != '0) |-> (st_reg.wr_active && (cmd.be_n != 4'hF)))
    else $error("lane written outside a write burst");

  chk_lane_map: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (st_reg.wr_active && !is_x8 && !is_x18 && cmd.be_n[2] && !cmd.be_n[3])
    |-> (mem_wr.mask[26:18] == 9'h000 && mem_wr.mask[35:27] == 9'h1FF))
    else $error("lane enable mapped to wrong bits");

  chk_enable_beats: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (st_reg.wr_addr_pend && !wr_acc) |=> (mem_wr.we [*4]))
    else $error("write burst did not sample enables on four edges");

  chk_cmode_first: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (load && !kmode) |-> (st_reg.out_ptr[0] ? c_rise : cn_rise))
    else $error("read word not timed by its output clock edge");

  chk_kmode_ref: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (load && kmode) |=> (O_Q_OE && ($past(st_reg.out_ptr[0]) == $past(cmd.kphase))))
    else $error("k mode word on wrong edge");

  chk_narrow_q: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (load && is_x8) |=> (O_Q[35:8] == 28'h000_0000))
    else $error("narrow width drove upper data bits");

  chk_dll_bypass: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (!sys_reg.dll_s2) |=> (O_DLL_BYPASS && O_DLL_READY))
    else $error("dll not bypassed while disabled");

  chk_cmd_on_k: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (rd_acc || wr_acc) |-> cmd.kphase)
    else $error("command taken off the true k edge");

  chk_read_ignore: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    rd_acc |=> !rd_acc ##1 !rd_acc)
    else $error("read taken on consecutive k rise");

  chk_write_start: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    wr_acc |=> st_reg.wr_addr_pend ##1 (st_reg.wr_active && st_reg.wr_beat == 2'h0))
    else $error("write burst did not start");

  chk_write_addr: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    st_reg.wr_addr_pend |=> (st_reg.wr_addr == $past(cmd.addr)))
    else $error("write address not taken on the following edge");

  chk_burst_four: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    rd_acc |=> st_reg.rd_active [*4])
    else $error("read burst shorter than four words");

  chk_addr_ignored: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    !rd_acc |=> $stable(st_reg.rd_addr))
    else $error("read address moved without a read");

  chk_echo_pair: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    kmode |=> (O_ECHO_CLOCK == $past(cmd.kphase) && O_ECHO_CLOCK_COMPLEMENT != O_ECHO_CLOCK))
    else $error("echo clocks not following the data edge");

  chk_q_stable: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    !load |=> $stable(O_Q))
    else $error("read data changed without a read word");

  chk_offset_order: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    rd_acc |=> st_reg.rd_beat == 2'h0 ##1 st_reg.rd_beat == 2'h1
           ##1 st_reg.rd_beat == 2'h2 ##1 st_reg.rd_beat == 2'h3
           ##1 (!st_reg.rd_active || $past(rd_acc)))  // a read taken at the last beat restarts
    else $error("burst offsets out of order");

  chk_write_reject: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    wr_acc |=> !wr_acc ##1 !wr_acc)
    else $error("write taken on consecutive k rise");

  chk_concurrent: assert property (
    @(posedge I_LINK_CLK) disable iff (!link_rst_n)
    (rd_acc && st_reg.wr_active && st_reg.wr_beat != 2'h3) |=> st_reg.wr_active)
    else $error("read disturbed the write burst");

  cov_read_out: cover property (@(posedge I_LINK_CLK) disable iff (!link_rst_n)
    load && st_reg.out_ptr == 2'h3);
  cov_write_full: cover property (@(posedge I_LINK_CLK) disable iff (!link_rst_n)
    st_reg.wr_active && st_reg.wr_beat == 2'h3);
  cov_both: cover property (@(posedge I_LINK_CLK) disable iff (!link_rst_n)
    st_reg.rd_active && st_reg.wr_active);
  cov_cmode: cover property (@(posedge I_LINK_CLK) disable iff (!link_rst_n)
    load && !kmode);

endmodule

// >>> rtl/b4sram_pkg.sv
// shared constants and carrier types for the burst-of-four split-port sram interface
package b4sram_pkg;

  localparam int ADDR_W    = 17;
  localparam int BEAT_W    = 2;
  localparam int MEM_AW    = ADDR_W + BEAT_W;
  localparam int WORD_W    = 36;
  localparam int LANE_W    = 9;
  localparam int LANES     = 4;
  localparam int NIBBLE_W  = 4;
  localparam int X8_W      = 8;
  localparam int X18_W     = 18;

  // width strap encoding
  localparam logic [1:0] WSEL_X8  = 2'h0;
  localparam logic [1:0] WSEL_X18 = 2'h1;

  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;

  // dll lock wait, least time so rounded up
  localparam int CLK_PERIOD_NS    = 100;
  localparam int DLL_LOCK_TIME_NS = 20000;
  localparam int DLL_LOCK_CYCLES  = (DLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DLL_LOCK_COUNT = 8'(DLL_LOCK_CYCLES);

  typedef struct packed {
    logic              kphase;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic [LANES-1:0]  be_n;
    logic              c;
    logic              c_n;
  } b4sram_cmd_type;

  typedef struct packed {
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [WORD_W-1:0] data;
    logic [WORD_W-1:0] mask;
  } b4sram_memwr_type;

  typedef struct packed {
    logic [1:0]                   wsel_s1;
    logic [1:0]                   wsel_s2;
    logic                         rdy_s1;
    logic                         rdy_s2;
    logic                         rd_acc_prev;
    logic                         wr_acc_prev;
    logic                         rd_active;
    logic [BEAT_W-1:0]            rd_beat;
    logic [ADDR_W-1:0]            rd_addr;
    logic                         fill_pend;
    logic [BEAT_W-1:0]            fill_ptr;
    logic [BEAT_W-1:0]            out_ptr;
    logic [2:0]                   pending;
    logic [LANES-1:0][WORD_W-1:0] rd_buf;
    logic                         wr_addr_pend;
    logic                         wr_active;
    logic [BEAT_W-1:0]            wr_beat;
    logic [ADDR_W-1:0]            wr_addr;
    logic [WORD_W-1:0]            q;
    logic                         q_oe;
    logic                         echo;
    logic                         c_prev;
    logic                         cn_prev;
  } b4sram_link_type;

  typedef struct packed {
    logic       dll_s1;
    logic       dll_s2;
    logic [7:0] lock_cnt;
    logic       bypass;
    logic       ready;
  } b4sram_sys_type;

  // clock and dll histories start at their idle high level: no false edge or bypass pulse
  localparam b4sram_link_type LINK_RESET = '{c_prev: 1'b1, cn_prev: 1'b1, default: '0};
  localparam b4sram_sys_type  SYS_RESET  = '{dll_s1: 1'b1, dll_s2: 1'b1, default: '0};
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;

endpackage

// >>> rtl/b4sram_mem.sv
// storage array with masked write port and registered read port
`timescale 1ns/1ps
module b4sram_mem (
  input  wire logic                               i_clk,
  input  wire logic                               i_rst_n,
  input  wire b4sram_pkg::b4sram_memwr_type       i_wr,
  input  wire logic                               i_rd_en,
  input  wire logic [b4sram_pkg::MEM_AW-1:0]      i_rd_addr,
  output logic      [b4sram_pkg::WORD_W-1:0]      o_rd_data
);

  logic [b4sram_pkg::WORD_W-1:0] mem_array [0:(2**b4sram_pkg::MEM_AW)-1];
  logic [b4sram_pkg::WORD_W-1:0] rd_data_reg;

  // array kept out of reset; only the read register is cleared
  always_ff @(posedge i_clk) begin
    if (i_wr.we) begin
      mem_array[i_wr.addr] <= (mem_array[i_wr.addr] & ~i_wr.mask) | (i_wr.data & i_wr.mask);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_reg <= b4sram_pkg::WORD_RESET;
    end else if (i_rd_en) begin
      rd_data_reg <= mem_array[i_rd_addr];
    end
  end

  assign o_rd_data = rd_data_reg;

endmodule

// >>> dv/b4sram_ctrl_model.sv
// memory controller model driving commands, data and clocks into the sram interface
`timescale 1ns/1ps
module b4sram_ctrl_model (
  input  wire logic        i_link_clk,
  input  wire logic        i_c_mode,
  output logic             o_k_phase,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic [16:0]      o_addr,
  output logic [35:0]      o_d,
  output logic [3:0]       o_be_n,
  output logic             o_out_clk,
  output logic             o_out_clk_n
);
  initial begin
    o_k_phase = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 17'h0_0000;
    o_d = 36'h0_0000_0000;
    o_be_n = 4'hf;
    o_out_clk = 1'b1;
    o_out_clk_n = 1'b1;
  end

  // one call is one link edge; every edge flips the phase so k and k_n stay apart
  task automatic step(input logic rn, input logic wn, input logic [16:0] a,
                      input logic [35:0] d, input logic [3:0] be);
    @(negedge i_link_clk);
    o_k_phase = ~o_k_phase;
    o_rd_n = rn;
    o_wr_n = wn;
    o_addr = a;
    o_d = d;
    o_be_n = be;
    o_out_clk = i_c_mode ? o_k_phase : 1'b1;
    o_out_clk_n = i_c_mode ? ~o_k_phase : 1'b1;
  endtask

  // idle lines keep changing so nothing stale looks like valid data
  task automatic idle();
    step(1'b1, 1'b1, ~o_addr, ~o_d, ~o_be_n);
  endtask

  // dup repeats the selects at the next k rise, which the device has to refuse
  task automatic burst(input logic rd, input logic [16:0] ra, input logic wr,
                       input logic [16:0] wa, input logic [3:0][35:0] d,
                       input logic [3:0][3:0] be, input logic dup);
    if (o_k_phase) begin
      idle();
    end
    step(~rd, ~wr, rd ? ra : ~o_addr, ~o_d, ~o_be_n);
    step(1'b1, 1'b1, wa, ~o_d, ~o_be_n);
    for (int n = 0; n < 4; n++) begin
      step(~(dup && rd && n == 0), ~(dup && wr && n == 0), (n == 1) ? ra : ~o_addr,
           d[n], be[n]);
    end
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the burst-of-four split-port sram interface
`timescale 1ns/1ps
module tb_top;
  logic              clk, lclk, rst_n, dll_n, c_mode, armed, e_oe, rt, wt, rprev, wprev;
  logic              k_ph, rd_n, wr_n, oc, oc_n, q_oe, echo, echo_n, byp, rdy, echo_last;
  logic [1:0]        wsel;
  logic [16:0]       addr, waddr, a, b;
  logic [35:0]       d, q, q_last;
  logic [3:0]        be_n;
  logic [3:0][35:0]  wd, wd2;
  logic [3:0][3:0]   be0, ber;
  logic [35:0]       mem [int];
  logic [35:0]       exp_q [int];
  int                failures, checks_done, seed, ecnt, wstart, bt, i;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end

  b4sram_top b4sram_top_inst (.I_CLK(clk), .I_RESET_N(rst_n), .I_LINK_CLK(lclk),
    .I_K_PHASE(k_ph), .I_READ_SELECT_N(rd_n), .I_WRITE_SELECT_N(wr_n),
    .I_SHARED_ADDRESS_BUS(addr), .I_D(d), .I_BYTE_LANE_WRITE_ENABLE_N(be_n),
    .I_OUT_CLK(oc), .I_OUT_CLK_N(oc_n), .I_DLL_DISABLE_N(dll_n), .I_WIDTH_SEL(wsel),
    .O_Q(q), .O_Q_OE(q_oe), .O_ECHO_CLOCK(echo), .O_ECHO_CLOCK_COMPLEMENT(echo_n),
    .O_DLL_BYPASS(byp), .O_DLL_READY(rdy));

  b4sram_ctrl_model b4sram_ctrl_model_inst (.i_link_clk(lclk), .i_c_mode(c_mode),
    .o_k_phase(k_ph), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_d(d),
    .o_be_n(be_n), .o_out_clk(oc), .o_out_clk_n(oc_n));

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // narrow widths keep only their low lanes, x8 splits two enables into nibbles
  function automatic logic [35:0] wmask(input logic [3:0] be);
    logic [35:0] m;
    m = 36'h0_0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (!be[k] && wsel == 2'h0 && k < 2) m[4*k +: 4] = 4'hf;
      else if (!be[k] && (wsel != 2'h1 || k < 2) && wsel != 2'h0) m[9*k +: 9] = 9'h1ff;
    end
    return m;
  endfunction

  function automatic logic [35:0] rmask();
    if (wsel == 2'h0) return 36'h0_0000_00ff;
    if (wsel == 2'h1) return 36'h0_0003_ffff;
    return 36'hf_ffff_ffff;
  endfunction

  // reference model: decides which selects are taken and what the array holds
  always @(posedge lclk) begin
    if (!rst_n) begin
      rprev = 1'b0;
      wprev = 1'b0;
      wstart = -100;
    end else begin
      ecnt++;
      if (k_ph) begin
        rt = !rd_n && !rprev;
        wt = !wr_n && !wprev;
        rprev = rt;
        wprev = wt;
        if (wt) wstart = ecnt;
        if (rt) begin
          for (int w = 0; w < 4; w++) exp_q[ecnt+3+w] = mem[{addr, w[1:0]}] & rmask();
        end
      end
      if (ecnt == wstart + 1) waddr = addr;
      bt = ecnt - wstart - 2;
      if (bt >= 0 && bt < 4) begin
        mem[{waddr, bt[1:0]}] = (mem[{waddr, bt[1:0]}] & ~wmask(be_n)) | (d & wmask(be_n));
      end
    end
  end

  always @(negedge lclk) begin
    if (armed) begin
      e_oe = exp_q.exists(ecnt);
      chk(q_oe === e_oe, "read output enable");
      if (e_oe) chk(q === exp_q[ecnt], "read word");
      else chk(q === q_last, "read bus moved without a read");
      chk(echo !== echo_last && echo_n === ~echo, "echo clock stalled");
      q_last = q;
      echo_last = echo;
    end
  end

  initial begin
    #3_000_000;
    failures++;
    close_out();
  end

  initial begin
    seed = 47739;
    failures = 0;
    checks_done = 0;
    ecnt = 0;
    armed = 1'b0;
    rst_n = 1'b0;
    dll_n = 1'b1;
    c_mode = 1'b0;
    wsel = 2'h2;
    be0 = '0;
    for (int m = 0; m < 3; m++) begin
      rst_n = 1'b0;
      dll_n = (m == 0);
      c_mode = (m == 1);
      wsel = 2'(2 - m);
      repeat (2) @(negedge clk);
      chk(q_oe === 1'b0 && echo_n === 1'b1, "reset outputs");
      rst_n = 1'b1;
      if (m == 0) begin
        repeat (100) b4sram_ctrl_model_inst.idle();
        chk(rdy === 1'b0 && byp === 1'b0, "dll lock wait cut short");
      end
      for (i = 0; i < 1000 && rdy !== 1'b1; i++) b4sram_ctrl_model_inst.idle();
      if (rdy !== 1'b1) begin
        failures++;
        close_out();
      end
      chk(byp === (m != 0), "dll bypass");
      repeat (4) b4sram_ctrl_model_inst.idle();
      // capture before the next link rise so the first armed check sees the echo move
      #1;
      q_last = q;
      echo_last = echo;
      armed = 1'b1;
      for (int r = 0; r < 4; r++) begin
        a = 17'($random(seed));
        b = a ^ 17'h0_0001;
        for (int n = 0; n < 4; n++) begin
          wd[n] = 36'({$random(seed), $random(seed)});
          wd2[n] = 36'({$random(seed), $random(seed)});
          ber[n] = 4'($random(seed));
        end
        b4sram_ctrl_model_inst.burst(1'b0, a, 1'b1, a, wd, be0, 1'b0);
        b4sram_ctrl_model_inst.burst(1'b0, a, 1'b1, b, wd2, be0, 1'b0);
        // read b while a takes a lane-masked write; repeated selects must be refused
        b4sram_ctrl_model_inst.burst(1'b1, b, 1'b1, a, wd2, ber, 1'b1);
        b4sram_ctrl_model_inst.burst(1'b1, a, 1'b0, a, wd, ber, 1'b1);
        b4sram_ctrl_model_inst.burst(1'b1, b, 1'b0, a, wd, ber, 1'b0);
        repeat (3) b4sram_ctrl_model_inst.idle();
      end
      repeat (8) b4sram_ctrl_model_inst.idle();
      armed = 1'b0;
    end
    close_out();
  end
endmodule
